// [pkg/bcd_cfg.svh]
`ifndef BCD_CFG_SVH
`define BCD_CFG_SVH
`define BCD_CLK_HZ 100000000
`define BCD_ENC_FMAX_HZ 20000
`define BCD_ENC_GAP_CYC ((`BCD_CLK_HZ + 4 * `BCD_ENC_FMAX_HZ - 1) / (4 * `BCD_ENC_FMAX_HZ))
`define BCD_SPD_WIN_US 1000
`define BCD_SPD_WIN_CYC (`BCD_SPD_WIN_US * (`BCD_CLK_HZ / 1000000))
`define BCD_CTRL_OFS 8'h00
`define BCD_STAT_OFS 8'h04
`define BCD_F_MODE 1:0
`define BCD_F_METH 3:2
`define BCD_F_PRESET 15:8
`define BCD_F_CMD 11:0
`define BCD_F_ROT 12
`define BCD_F_ON 13
`define BCD_F_REFUSED 14
`define BCD_F_BRAKE 15
`define BCD_F_SPEED 23:16
`define BCD_PRESET_RST 8'h20
`define BCD_FULL 12'hFFF
`define BCD_MID 12'h800
`define BCD_SAT16 16'hFFFF
`define BCD_DIV_LAST 4'hB
`endif

// [pkg/bcd_pkg.sv]
package bcd_pkg;
   typedef enum logic [1:0] {
      MD_OL_SPD = 2'h0,
      MD_CL_SPD = 2'h1,
      MD_PRESET = 2'h2,
      MD_TORQUE = 2'h3
   } bcd_mode_e;
   typedef enum logic [1:0] {
      CM_ANALOG = 2'h0,
      CM_PWM = 2'h1,
      CM_PWM_DIR = 2'h2,
      CM_RSVD = 2'h3
   } bcd_meth_e;
   typedef enum logic [1:0] {
      DV_WAIT = 2'h0,
      DV_RUN = 2'h1,
      DV_DONE = 2'h3
   } bcd_dv_e;
   typedef struct packed {
      logic ccw;
      logic [11:0] mag;
   } bcd_cmd_s;
   typedef struct packed {
      logic prev;
      logic [15:0] hi;
      logic [15:0] per;
      logic [15:0] div_per;
      logic [15:0] rem;
      logic [11:0] quo;
      logic [3:0] cnt;
      bcd_dv_e st;
      logic [11:0] duty;
   } bcd_dm_s;
   typedef struct packed {
      logic [1:0] ph;
      logic [10:0] gap;
      logic pend;
      logic pccw;
      logic dir;
      logic adv;
   } bcd_qg_s;
   typedef struct packed {
      bcd_mode_e mode;
      bcd_meth_e meth;
      logic [7:0] preset;
      logic ap_vld;
      logic ap_wr;
      logic [7:0] ap_addr;
      logic [31:0] rdata;
      logic rdy;
      logic [2:0] sec;
      logic tach;
      logic rot_ccw;
      logic step;
      logic [16:0] win;
      logic [7:0] spd_cnt;
      logic [7:0] speed;
      logic [11:0] integ;
      logic refused;
      logic drive_on;
      bcd_cmd_s dem;
      logic brake;
   } bcd_top_s;
endpackage

// [hdl/bcd_duty_meter.sv]
`include "bcd_cfg.svh"
module bcd_duty_meter import bcd_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pwm_in,
   output logic [11:0] duty
);
   bcd_dm_s q;
   bcd_dm_s d;
   logic [16:0] r2;

   always_comb begin
      d = q;
      r2 = {q.rem, 1'b0};
      d.prev = pwm_in;
      if (q.per != `BCD_SAT16) begin
         d.per = q.per + 16'h1;
      end
      if (pwm_in && q.hi != `BCD_SAT16) begin
         d.hi = q.hi + 16'h1;
      end
      case (q.st)
         DV_RUN: begin
            // Restoring divide: duty = high * 4096 / period
            if (r2 >= {1'b0, q.div_per}) begin
               d.rem = 16'(r2 - {1'b0, q.div_per});
               d.quo = {q.quo[10:0], 1'b1};
            end else begin
               d.rem = r2[15:0];
               d.quo = {q.quo[10:0], 1'b0};
            end
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == `BCD_DIV_LAST) begin
               d.st = DV_DONE;
            end
         end
         DV_DONE: begin
            d.duty = q.quo;
            d.st = DV_WAIT;
         end
         default: d.st = DV_WAIT;
      endcase
      // Period runs rising edge to rising edge; high equal to period saturates to full
      if (pwm_in && !q.prev) begin
         d.per = 16'h1;
         d.hi = 16'h1;
         if (q.per != `BCD_SAT16) begin
            d.rem = q.hi;
            d.div_per = q.per;
            d.quo = 12'h0;
            d.cnt = 4'h0;
            d.st = DV_RUN;
         end
      end else if (q.per == `BCD_SAT16) begin
         // Input stuck: read it as 0 or 100 percent
         d.duty = pwm_in ? `BCD_FULL : 12'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign duty = q.duty;

   a_duty_update: assert property (@(posedge hclk) disable iff (!hresetn)
      q.st == DV_DONE |=> duty == $past(q.quo)) else $error("duty not updated");
endmodule

// [hdl/bcd_quad_gen.sv]
`include "bcd_cfg.svh"
module bcd_quad_gen import bcd_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic step,
   input wire logic ccw,
   output logic enc_a,
   output logic enc_b,
   output logic adv
);
   bcd_qg_s q;
   bcd_qg_s d;
   logic nd;

   always_comb begin
      d = q;
      nd = step ? ccw : q.pccw;
      d.adv = 1'b0;
      if (q.gap != 11'h0) begin
         d.gap = q.gap - 11'h1;
      end
      // One step may wait out the gap; more than that exceeds the response limit
      if (step) begin
         d.pend = 1'b1;
         d.pccw = ccw;
      end
      if (q.gap == 11'h0 && (q.pend || step)) begin
         d.ph = nd ? {~q.ph[0], q.ph[1]} : {q.ph[0], ~q.ph[1]};
         d.gap = 11'(`BCD_ENC_GAP_CYC - 1);
         d.pend = 1'b0;
         d.dir = nd;
         d.adv = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign enc_a = q.ph[1];
   assign enc_b = q.ph[0];
   assign adv = q.adv;

   a_quad_order: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(q.ph) |-> q.ph == (q.dir ? {~$past(q.ph[0]), $past(q.ph[1])}
                                        : {$past(q.ph[0]), ~$past(q.ph[1])}))
      else $error("quadrature order wrong");
   a_enc_gap: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(q.ph) |-> $past(q.gap) == 11'h0) else $error("edge too soon");
endmodule

// [hdl/bcd_drive.sv]
// Summary of operation
// - Plain PWM duty sets current demand, zero duty none, full duty full.
// - Plain PWM command accepted only in open- or closed-loop speed mode.
// - Two quadrature channels, rate rpm times counts over 60, capped at 20 kHz.
// - Encoder channels give speed feedback in closed-loop and preset modes.
// - Direction output from halls: low clockwise, high counter-clockwise.
// - Direction input high commands counter-clockwise, low clockwise.
// - Direction input honoured in both speed, preset and torque modes.
// - Combined input: 0% full CCW, 50% zero, 100% full CW.
// - Combined command accepted only in open- or closed-loop speed mode.
// - Enable low runs the drive; enable high stops it and lets it coast.
// - Enable gates the motor in every method and mode.
// - One of four modes, command from analog, PWM or combined input.
// - Open-loop speed applies drive proportional to command, no feedback.
// - Closed-loop speed regulates speed from encoder feedback.
// - Preset mode regulates a configured fixed speed the same way.
// - Torque mode sets current open-loop from the analog level.
// - Analog zero volts is zero demand, four volts full, linear between.
// - Drive and brake in both directions under every method.
// - Tachometer output toggles at every commutation, either direction.
`include "bcd_cfg.svh"
module bcd_drive import bcd_pkg::*; #(
   parameter int unsigned SPD_WIN_CYC = `BCD_SPD_WIN_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic pwm_in,
   input wire logic dir_pwm_in,
   input wire logic enable_n,
   input wire logic [11:0] adc_level,
   input wire logic [2:0] hall,
   output logic tach,
   output logic rot_ccw,
   output logic enc_a,
   output logic enc_b,
   output logic drive_on,
   output bcd_cmd_s demand,
   output logic brake
);
   bcd_top_s q;
   bcd_top_s d;
   bcd_cmd_s c;
   logic ok;
   logic spd_mode;
   logic [2:0] cur;
   logic [7:0] tgt;
   logic [8:0] err;
   logic [13:0] acc;
   logic [11:0] dd;
   logic [11:0] duty_p;
   logic [11:0] duty_d;
   logic enc_adv;
   logic [31:0] stat;

   function automatic logic [2:0] bcd_hall_sec(input logic [2:0] h);
      case (h)
         3'b001: return 3'h0;
         3'b011: return 3'h1;
         3'b010: return 3'h2;
         3'b110: return 3'h3;
         3'b100: return 3'h4;
         3'b101: return 3'h5;
         default: return 3'h7;
      endcase
   endfunction

   function automatic logic [2:0] bcd_sec_next(input logic [2:0] s);
      return (s == 3'h5) ? 3'h0 : 3'(s + 3'h1);
   endfunction

   // Doubles a half-scale offset to full scale, saturating at the top
   function automatic logic [11:0] bcd_dbl(input logic [11:0] v);
      return v[11] ? `BCD_FULL : {v[10:0], v[10]};
   endfunction

   // Two meters: plain PWM pin and the shared direction pin
   bcd_duty_meter u_meter_pwm (
      .hclk(hclk),
      .hresetn(hresetn),
      .pwm_in(pwm_in),
      .duty(duty_p)
   );

   bcd_duty_meter u_meter_dir (
      .hclk(hclk),
      .hresetn(hresetn),
      .pwm_in(dir_pwm_in),
      .duty(duty_d)
   );

   bcd_quad_gen u_quad (
      .hclk(hclk),
      .hresetn(hresetn),
      .step(q.step),
      .ccw(q.rot_ccw),
      .enc_a(enc_a),
      .enc_b(enc_b),
      .adv(enc_adv)
   );

   always_comb begin
      d = q;
      c = '0;
      ok = 1'b0;
      dd = 12'h0;
      cur = bcd_hall_sec(hall);
      spd_mode = (q.mode == MD_OL_SPD) || (q.mode == MD_CL_SPD);
      d.rdy = 1'b1;
      d.step = 1'b0;

      // Commutation: tach toggles, direction from sector order
      if (cur != 3'h7 && cur != q.sec) begin
         d.sec = cur;
         if (q.sec != 3'h7) begin
            d.tach = ~q.tach;
            d.step = 1'b1;
            d.rot_ccw = (cur != bcd_sec_next(q.sec));
         end
      end

      // Command source decode
      case (q.meth)
         CM_ANALOG: begin
            c.mag = adc_level;
            c.ccw = dir_pwm_in;
            ok = 1'b1;
         end
         CM_PWM: begin
            c.mag = duty_p;
            c.ccw = dir_pwm_in;
            ok = spd_mode;
         end
         CM_PWM_DIR: begin
            if (duty_d >= `BCD_MID) begin
               dd = duty_d - `BCD_MID;
               c.ccw = 1'b0;
            end else begin
               dd = `BCD_MID - duty_d;
               c.ccw = 1'b1;
            end
            c.mag = bcd_dbl(dd);
            ok = spd_mode;
         end
         default: begin
            c = '0;
            ok = 1'b0;
         end
      endcase
      if (q.mode == MD_PRESET) begin
         // Preset runs on enable alone; only the direction level is read
         c.ccw = dir_pwm_in;
         ok = 1'b1;
      end

      // Speed from encoder steps per window
      tgt = (q.mode == MD_PRESET) ? q.preset : c.mag[11:4];
      err = {1'b0, tgt} - {1'b0, q.speed};
      acc = {2'b00, q.integ} + {{5{err[8]}}, err};
      if (enc_adv && q.spd_cnt != 8'hFF) begin
         d.spd_cnt = q.spd_cnt + 8'h1;
      end
      d.win = q.win + 17'h1;
      if (q.win == 17'(SPD_WIN_CYC - 1)) begin
         d.win = 17'h0;
         d.speed = q.spd_cnt;
         d.spd_cnt = {7'h0, enc_adv};
         // Integral loop trims drive until speed meets target
         if (acc[13]) begin
            d.integ = 12'h0;
         end else if (acc[12]) begin
            d.integ = `BCD_FULL;
         end else begin
            d.integ = acc[11:0];
         end
      end

      // Enable gates every mode; disabled means coast, not brake
      d.refused = !ok;
      d.drive_on = !enable_n && ok;
      d.dem.ccw = c.ccw;
      case (q.mode)
         MD_OL_SPD: d.dem.mag = c.mag;
         MD_CL_SPD: d.dem.mag = q.integ;
         MD_PRESET: d.dem.mag = q.integ;
         MD_TORQUE: d.dem.mag = c.mag;
         default: d.dem.mag = 12'h0;
      endcase
      if (!d.drive_on) begin
         d.dem = '0;
         d.integ = 12'h0;
      end
      // Opposing rotation while moving is the braking quadrant
      d.brake = d.drive_on && q.speed != 8'h0 && (q.rot_ccw != c.ccw);

      // Register write in the data phase
      if (q.ap_vld && q.ap_wr && q.ap_addr == `BCD_CTRL_OFS) begin
         d.mode = bcd_mode_e'(hwdata[`BCD_F_MODE]);
         d.meth = bcd_meth_e'(hwdata[`BCD_F_METH]);
         d.preset = hwdata[`BCD_F_PRESET];
      end
      d.ap_vld = hsel && htrans[1] && hready;
      d.ap_wr = hwrite;
      d.ap_addr = haddr[7:0];
      stat = 32'h0;
      stat[`BCD_F_CMD] = q.dem.mag;
      stat[`BCD_F_ROT] = q.rot_ccw;
      stat[`BCD_F_ON] = q.drive_on;
      stat[`BCD_F_REFUSED] = q.refused;
      stat[`BCD_F_BRAKE] = q.brake;
      stat[`BCD_F_SPEED] = q.speed;
      // Read sees a write still in its data phase
      d.rdata = 32'h0;
      if (d.ap_vld && !hwrite) begin
         if (haddr[7:0] == `BCD_CTRL_OFS) begin
            d.rdata[`BCD_F_MODE] = d.mode;
            d.rdata[`BCD_F_METH] = d.meth;
            d.rdata[`BCD_F_PRESET] = d.preset;
         end else if (haddr[7:0] == `BCD_STAT_OFS) begin
            d.rdata = stat;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.rdy <= 1'b1;
         q.sec <= 3'h7;
         q.preset <= `BCD_PRESET_RST;
      end else begin
         q <= d;
      end
   end

   assign hrdata = q.rdata;
   assign hreadyout = q.rdy;
   assign hresp = 1'b0;
   assign tach = q.tach;
   assign rot_ccw = q.rot_ccw;
   assign drive_on = q.drive_on;
   assign demand = q.dem;
   assign brake = q.brake;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_coast_disable: assert property (enable_n |=> !drive_on && demand == '0)
      else $error("drive not coasting");
   a_gate_all: assert property (!drive_on |-> demand.mag == 12'h0 && !brake)
      else $error("demand while off");
   a_pwm_refused: assert property (q.meth == CM_PWM && q.mode == MD_TORQUE
      |=> !drive_on && q.refused) else $error("pwm taken in torque");
   a_pdir_refused: assert property (q.meth == CM_PWM_DIR && q.mode == MD_TORQUE
      |=> !drive_on) else $error("pwm dir taken in torque");
   a_pwm_demand: assert property (q.mode == MD_OL_SPD && q.meth == CM_PWM && !enable_n
      |=> demand.mag == $past(duty_p)) else $error("pwm demand wrong");
   a_pdir_mid: assert property (q.mode == MD_OL_SPD && q.meth == CM_PWM_DIR
      && !enable_n && duty_d == `BCD_MID |=> demand.mag == 12'h0)
      else $error("mid duty not zero");
   a_pdir_full: assert property (spd_mode && q.meth == CM_PWM_DIR
      && !enable_n && duty_d == 12'h0 |=> demand.ccw) else $error("zero duty not ccw");
   a_torque_analog: assert property (q.mode == MD_TORQUE && q.meth == CM_ANALOG
      && !enable_n |=> demand.mag == $past(adc_level)) else $error("torque level wrong");
   a_dir_input: assert property (q.mode == MD_OL_SPD && q.meth == CM_ANALOG
      && !enable_n |=> demand.ccw == $past(dir_pwm_in)) else $error("direction wrong");
   a_tach_toggle: assert property ($changed(tach) |-> q.step)
      else $error("tach moved without commutation");
   a_rot_dir: assert property (q.step |->
      rot_ccw == (q.sec != bcd_sec_next($past(q.sec)))) else $error("rotation output wrong");

   c_brake: cover property (brake);
   c_refused: cover property (q.refused && !enable_n);
   c_loop_trim: cover property (q.mode == MD_CL_SPD && $changed(q.integ));
   c_preset_run: cover property (q.mode == MD_PRESET && drive_on && demand.mag != 12'h0);
endmodule

// [testbench/bcd_ctl_model.sv]
// Stand-in for the user motion controller on the connector side
module bcd_ctl_model import bcd_pkg::*; (
   input wire logic hclk,
   output logic pwm_in,
   output logic dir_pwm_in,
   output logic enable_n,
   output logic [11:0] adc_level,
   output logic [2:0] hall
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] sel;
   logic dir;
   logic [15:0] per;
   logic [15:0] hi;
   logic [15:0] cnt;
   int idx;
   logic [2:0] tab [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
   initial begin
      sel = 2'h0;
      dir = 1'b0;
      per = 16'h0FA0;
      hi = 16'h0000;
      cnt = 16'h0000;
      idx = 0;
      enable_n = 1'b1;
      adc_level = 12'h000;
      hall = 3'h1;
      pwm_in = 1'b0;
      dir_pwm_in = 1'b0;
   end
   // Counter never reset by the tasks, so no two writers race at one edge
   always @(posedge hclk) begin
      cnt <= (cnt + 16'h0001 >= per) ? 16'h0000 : cnt + 16'h0001;
      pwm_in <= (sel == 2'h1) && (cnt < hi);
      dir_pwm_in <= (sel == 2'h2) ? (cnt < hi) : dir;
   end
   // Period in cycles: 4000 for plain, 40000 for combined
   task automatic set_pwm(input logic [1:0] s, input logic [15:0] p, input logic [15:0] h);
      sel <= s;
      per <= p;
      hi <= h;
   endtask
   task automatic set_lvl(input logic en_n, input logic d, input logic [11:0] a);
      enable_n <= en_n;
      dir <= d;
      adc_level <= a;
   endtask
   // One sector per call, clockwise order 001 011 010 110 100 101
   task automatic step(input logic cw);
      idx = cw ? (idx + 1) % 6 : (idx + 5) % 6;
      hall <= tab[idx];
   endtask
endmodule

// [testbench/bcd_drive_tb_top.sv]
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("[FAIL] %0t: got %0h expected %0h", $time, (g), (e)); \
   end \
end
module bcd_drive_tb_top import bcd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, hall;
   logic pwm_in, dir_pwm_in, enable_n, tach, rot_ccw, enc_a, enc_b, drive_on, brake;
   logic [11:0] adc_level;
   bcd_cmd_s demand;
   int fail_count, checks_done;

   bcd_drive #(.SPD_WIN_CYC(200)) bcd_drive_inst (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pwm_in(pwm_in), .dir_pwm_in(dir_pwm_in), .enable_n(enable_n),
      .adc_level(adc_level), .hall(hall), .tach(tach), .rot_ccw(rot_ccw), .enc_a(enc_a),
      .enc_b(enc_b), .drive_on(drive_on), .demand(demand), .brake(brake));
   bcd_ctl_model bcd_ctl_model_inst (.hclk(hclk), .pwm_in(pwm_in),
      .dir_pwm_in(dir_pwm_in), .enable_n(enable_n), .adc_level(adc_level), .hall(hall));

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Holds each phase until hready is seen high; data taken at that edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      `CHK(hresp, 1'b0);
      if (n >= 100) fail_count++;
   endtask
   task automatic wait_mag(input logic [11:0] lo, input logic [11:0] hi, input int lim);
      int n;
      n = 0;
      while (!(demand.mag >= lo && demand.mag <= hi) && n < lim) begin
         @(posedge hclk);
         n++;
      end
      cyc(1);
   endtask
   task automatic t_regs();
      logic [31:0] rd;
      logic [15:0] ctl [5] = '{16'h2007, 16'h200A, 16'h2005, 16'h2008, 16'h2003};
      logic [4:0] ref_exp = 5'b00001;
      `CHK({hreadyout, tach, rot_ccw, enc_a, enc_b, drive_on, demand, brake}, 20'h80000);
      ahb(1'b0, 8'h00, 32'h00000000, rd);
      `CHK(rd, 32'h00002000);
      ahb(1'b0, 8'h08, 32'h00000000, rd);
      `CHK(rd, 32'h00000000);
      bcd_ctl_model_inst.set_lvl(1'b0, 1'b0, 12'h000);
      for (int k = 0; k < 5; k++) begin
         ahb(1'b1, 8'h00, {16'h0000, ctl[k]}, rd);
         ahb(1'b0, 8'h00, 32'h00000000, rd);
         `CHK(rd, {16'h0000, ctl[k]});
         cyc(3);
         ahb(1'b0, 8'h04, 32'h00000000, rd);
         `CHK(rd[14], ref_exp[k]);
         if (k == 0) `CHK({rd[13], drive_on}, 2'b00);
      end
   endtask
   // Preset magnitude comes from the speed loop, so it is judged after a few windows
   task automatic t_analog();
      logic [31:0] rd;
      logic [15:0] ctl [3] = '{16'h2003, 16'h2000, 16'h2002};
      logic [11:0] adc [3] = '{12'h123, 12'hFFF, 12'h000};
      for (int m = 0; m < 3; m++) begin
         ahb(1'b1, 8'h00, {16'h0000, ctl[m]}, rd);
         for (int k = 0; k < 3; k++) begin
            bcd_ctl_model_inst.set_lvl(1'b0, k[0], adc[k]);
            cyc(4);
            `CHK(drive_on, 1'b1);
            `CHK(demand.ccw, k[0]);
            `CHK(brake, 1'b0);
            if (m < 2) `CHK(demand.mag, adc[k]);
         end
         // No hall steps, so speed stays 0 and the loop must push demand up
         if (m == 2) begin
            cyc(400);
            `CHK(demand.mag >= 12'h020, 1'b1);
         end
         bcd_ctl_model_inst.set_lvl(1'b1, 1'b0, 12'h456);
         cyc(4);
         `CHK({drive_on, demand}, 14'h0000);
      end
   endtask
   task automatic t_pwm();
      logic [31:0] rd;
      logic [15:0] hi [2] = '{16'h07D0, 16'h03E8};
      logic [11:0] ex [2] = '{12'h800, 12'h400};
      ahb(1'b1, 8'h00, 32'h00002004, rd);
      bcd_ctl_model_inst.set_lvl(1'b0, 1'b1, 12'h000);
      for (int k = 0; k < 2; k++) begin
         bcd_ctl_model_inst.set_pwm(2'h1, 16'h0FA0, hi[k]);
         wait_mag(ex[k] - 12'h002, ex[k] + 12'h002, 12000);
         `CHK(demand.mag inside {[ex[k] - 12'h002 : ex[k] + 12'h002]}, 1'b1);
         `CHK(demand.ccw, 1'b1);
      end
      // One combined period is 40000 cycles, so only one duty fits the run
      ahb(1'b1, 8'h00, 32'h00002008, rd);
      bcd_ctl_model_inst.set_pwm(2'h2, 16'h9C40, 16'h2710);
      wait_mag(12'h7FC, 12'h805, 90000);
      `CHK((demand.mag >= 12'h7FC) && (demand.mag <= 12'h805), 1'b1);
      `CHK(demand.ccw, 1'b1);
      bcd_ctl_model_inst.set_pwm(2'h0, 16'h0FA0, 16'h0000);
   endtask
   task automatic t_hall();
      logic [31:0] rd;
      logic t;
      logic [1:0] e;
      logic cw;
      t = 1'b0;
      e = 2'h0;
      ahb(1'b1, 8'h00, 32'h00002000, rd);
      for (int i = 0; i < 6; i++) begin
         cw = (i < 3);
         cyc(1260);
         bcd_ctl_model_inst.step(cw);
         t = ~t;
         e = cw ? e + 2'h1 : e - 2'h1;
         cyc(4);
         `CHK(tach, t);
         `CHK(rot_ccw, ~cw);
         `CHK({enc_a, enc_b}, {e[1], ^e});
      end
      // Second step inside the gap must wait for the rate cap
      cyc(1260);
      bcd_ctl_model_inst.step(1'b1);
      cyc(10);
      bcd_ctl_model_inst.step(1'b1);
      cyc(10);
      `CHK({enc_a, enc_b}, 2'b01);
      cyc(1250);
      `CHK({enc_a, enc_b}, 2'b11);
   endtask
   task automatic test_done();
      $display("Checks %0d, failures %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      fail_count = 0;
      checks_done = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_analog();
      t_pwm();
      t_hall();
      test_done();
   end
   // Longest path is two combined periods plus the hall walk
   initial begin
      repeat (115000) @(posedge hclk);
      fail_count++;
      test_done();
   end
endmodule
